/* pkg/nco_pkg.sv */
// Purpose: Shared constants for the phase accumulator core
// Assumes: One 200 MHz clock, synchronous active-high reset
// Notes: Register indices double as byte addresses times four
package nco_pkg;
  localparam int unsigned ACC_W = 48;
  localparam int unsigned PHASE_W = 14;
  localparam int unsigned SCALE_W = 10;
  localparam int unsigned ADDR_W = 8;
  // *****************************************************
  // Register map (byte addresses, 32-bit data)
  // *****************************************************
  localparam logic [7:0] REG_STEP_LO = 8'h00;
  localparam logic [7:0] REG_STEP_HI = 8'h04;
  localparam logic [7:0] REG_PHASE = 8'h08;
  localparam logic [7:0] REG_SCALE = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_PHASE_OUT = 8'h18;
  localparam int unsigned CTRL_PD_BIT = 4;
  // *****************************************************
  // Reset values
  // *****************************************************
  localparam logic [47:0] STEP_RST = 48'h0000_0000_0000;
  localparam logic [13:0] PHASE_RST = 14'h0000;
  // Nearest code to 20 mA at 120 uA: 120 uA * (72 + 192*505/1024) is 20.0 mA
  localparam logic [9:0] SCALE_RST = 10'h01F9;
  localparam logic PD_RST = 1'b0;
  typedef enum logic [1:0] {
    CLK_CRYSTAL = 2'b00,
    CLK_EXT_MULT = 2'b01,
    CLK_BYPASS = 2'b11
  } clk_cfg_t;
endpackage : nco_pkg

/* hw/edge_sync.sv */
// Purpose: Two-stage synchroniser with rising-edge pulse
// Assumes: Asynchronous pin input, single clock domain
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module edge_sync
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out
);
  logic meta;
  logic sync;
  logic prev;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
    end
  end
  assign level_out = sync;
  assign rise_out = sync & ~prev;
endmodule : edge_sync

/* hw/phase_accum.sv */
// Purpose: Modulo 2^48 phase accumulator with phase offset add
// Assumes: Advances on every enabled sampling cycle
// Notes: Carry out of the top bit is dropped from acc_out and registered on wrap_out
`timescale 1ns/10ps
module phase_accum
  import nco_pkg::*;
#(
  parameter int unsigned WIDTH = ACC_W,
  parameter int unsigned PW = PHASE_W
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] step_in,
  input wire logic [PW-1:0] offset_in,
  output logic [WIDTH-1:0] acc_out,
  output logic [PW-1:0] phase_out,
  output logic wrap_out
);
  logic [WIDTH:0] sum;
  assign sum = {1'b0, acc_out} + {1'b0, step_in};
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      acc_out <= '0;
      phase_out <= '0;
      wrap_out <= 1'b0;
    end
    else
    begin
      acc_out <= sum[WIDTH-1:0]; // R1 R2 R3
      wrap_out <= sum[WIDTH]; // R3
      phase_out <= acc_out[WIDTH-1 -: PW] + offset_in; // R5 R15
    end
  end
endmodule : phase_accum

/* hw/dds_core.sv */
//
// Contract
// R1: Phase accumulator is a 48-bit modulo counter stepped by the step word.
// R2: Each sampling cycle the step word adds to the running total.
// R3: Overflow wraps keeping the remainder; wrap rate sets output frequency.
// R4: Host computes step word as round(2^48 * fout / fs).
// R5: Programmable 14-bit phase offset shifts phase by 2pi*value/2^14.
// R6: Holds 10-bit DAC scale code setting full-scale current.
// R7: Reset loads scale code giving 20 mA with recommended resistor.
// R8: Multiplier active when control bit 4 at 0x10 is zero; one bypasses.
// R9: Source select low enables crystal amplifier; high accepts external clock.
// R10: Source select never disables the multiplier by itself.
// R11: Bypassed multiplier means reference input directly clocks sampling.
// R12: Three clock configurations: bypass, external to multiplier, crystal to multiplier.
// R13: Commit strobe rising edge copies staged words into active registers.
// R14: Active-high chip reset holds the device in reset.
// R15: Phase offset adds modulo 2^14 to top 14 accumulator bits.
//
// Purpose: Top of the synthesizer's digital phase core
// Assumes: clk_in is the sampling clock; pins pass a two-flop synchroniser
// Notes: Staged words take effect only on a commit strobe rising edge
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module dds_core
  import nco_pkg::*;
#(
  parameter int unsigned STEP_W = ACC_W,
  parameter int unsigned OFFS_W = PHASE_W,
  parameter int unsigned CODE_W = SCALE_W
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic commit_in,
  input wire logic osc_source_select_in,
  output logic [OFFS_W-1:0] phase_out,
  output logic [CODE_W-1:0] dac_scale_code_out,
  output logic xtal_amp_enable_out,
  output logic mult_enable_out,
  output logic bypass_select_out,
  output logic [1:0] clk_cfg_out
);
  // ****************************************************
  // Parameter checks
  // ****************************************************
  // Bus slices follow the fixed register layout, so other widths would misplace fields
  if (STEP_W != ACC_W || OFFS_W != PHASE_W || CODE_W != SCALE_W)
  begin : g_bad_width
    $error("Widths must match the register layout");
  end

  // ****************************************************
  // Staged and active registers
  // ****************************************************
  logic [STEP_W-1:0] staged_step;
  logic [OFFS_W-1:0] staged_phase;
  logic [CODE_W-1:0] staged_scale;
  logic staged_pd;
  logic [STEP_W-1:0] freq_step_word;
  logic [OFFS_W-1:0] phase_offset;
  logic [CODE_W-1:0] dac_scale_code;
  logic clk_mult_powerdown;
  logic src_level;
  logic commit_rise;
  logic [STEP_W-1:0] acc_value;
  logic [OFFS_W-1:0] acc_phase;
  logic wrap_flag;
  logic [31:0] next_rdata;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  // Both pins are asynchronous, so each passes two flops before any logic reads it
  edge_sync u_commit_sync
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(commit_in),
    .level_out(),
    .rise_out(commit_rise)
  );

  edge_sync u_src_sync
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(osc_source_select_in),
    .level_out(src_level),
    .rise_out()
  );

  // ****************************************************
  // Write decode
  // ****************************************************
  function automatic logic reg_hit(input logic strobe, input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
    return strobe && (addr == offset);
  endfunction : reg_hit

  wire wr_step_lo = reg_hit(wr_in, addr_in, REG_STEP_LO);
  wire wr_step_hi = reg_hit(wr_in, addr_in, REG_STEP_HI);
  wire wr_phase = reg_hit(wr_in, addr_in, REG_PHASE);
  wire wr_scale = reg_hit(wr_in, addr_in, REG_SCALE);
  wire wr_ctrl = reg_hit(wr_in, addr_in, REG_CTRL);

  // ****************************************************
  // Staged words, written by software
  // ****************************************************
  always_ff @(posedge clk_in)
  begin
    if (rst_in) // R14
    begin
      staged_step <= STEP_RST;
    end
    else if (wr_step_lo)
    begin
      staged_step[31:0] <= wdata_in;
    end
    else if (wr_step_hi)
    begin
      staged_step[47:32] <= wdata_in[15:0];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      staged_phase <= PHASE_RST;
    end
    else if (wr_phase)
    begin
      staged_phase <= wdata_in[OFFS_W-1:0];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      staged_scale <= SCALE_RST;
    end
    else if (wr_scale)
    begin
      staged_scale <= wdata_in[CODE_W-1:0]; // R6
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      staged_pd <= PD_RST;
    end
    else if (wr_ctrl)
    begin
      staged_pd <= wdata_in[CTRL_PD_BIT]; // R8
    end
  end

  // ****************************************************
  // Active words, loaded on commit
  // ****************************************************
  // Active words move only on commit, so a half-written step never reaches the accumulator
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      freq_step_word <= STEP_RST;
    end
    else if (commit_rise) // R13
    begin
      freq_step_word <= staged_step;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      phase_offset <= PHASE_RST;
    end
    else if (commit_rise) // R13
    begin
      phase_offset <= staged_phase; // R5
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dac_scale_code <= SCALE_RST; // R7
    end
    else if (commit_rise) // R13
    begin
      dac_scale_code <= staged_scale; // R6
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      clk_mult_powerdown <= PD_RST; // R8
    end
    else if (commit_rise) // R13
    begin
      clk_mult_powerdown <= staged_pd;
    end
  end

  // ****************************************************
  // Accumulator
  // ****************************************************
  phase_accum #(
    .WIDTH(STEP_W),
    .PW(OFFS_W)
  ) u_accum
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .step_in(freq_step_word),
    .offset_in(phase_offset),
    .acc_out(acc_value),
    .phase_out(acc_phase),
    .wrap_out(wrap_flag)
  );

  // ****************************************************
  // Clock source selection
  // ****************************************************
  // Multiplier depends only on the powerdown bit, never on the select pin
  wire mult_on = ~clk_mult_powerdown; // R8 R10
  wire xtal_on = ~src_level; // R9
  clk_cfg_t next_cfg;
  assign next_cfg = clk_mult_powerdown ? CLK_BYPASS : (src_level ? CLK_EXT_MULT : CLK_CRYSTAL); // R12

  // ****************************************************
  // Output registers
  // ****************************************************
  // Every output leaves from its own flop, so pins never glitch on decode changes
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      phase_out <= '0;
    end
    else
    begin
      phase_out <= acc_phase; // R15
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dac_scale_code_out <= SCALE_RST;
    end
    else
    begin
      dac_scale_code_out <= dac_scale_code;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      xtal_amp_enable_out <= 1'b1;
    end
    else
    begin
      xtal_amp_enable_out <= xtal_on; // R9
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mult_enable_out <= 1'b1;
    end
    else
    begin
      mult_enable_out <= mult_on; // R10
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      bypass_select_out <= 1'b0;
    end
    else
    begin
      bypass_select_out <= clk_mult_powerdown; // R11
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      clk_cfg_out <= CLK_CRYSTAL;
    end
    else
    begin
      clk_cfg_out <= next_cfg; // R12
    end
  end

  // ****************************************************
  // Register read
  // ****************************************************
  // Reads show the active words, so software can confirm a commit landed
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (addr_in)
      REG_STEP_LO: next_rdata = freq_step_word[31:0];
      REG_STEP_HI: next_rdata = {16'h0000, freq_step_word[47:32]};
      REG_PHASE: next_rdata = {18'h0_0000, phase_offset};
      REG_SCALE: next_rdata = {22'h00_0000, dac_scale_code};
      REG_CTRL: next_rdata = {27'h000_0000, clk_mult_powerdown, 4'h0};
      REG_STATUS: next_rdata = {28'h000_0000, wrap_flag, src_level, clk_cfg_out};
      REG_PHASE_OUT: next_rdata = {18'h0_0000, acc_value[47 -: 14]};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= 32'h0000_0000;
    else if (rd_in)
      rdata_out <= next_rdata;
    else
      rdata_out <= 32'h0000_0000;
  end
endmodule : dds_core

/* bench/dds_core_checker.sv */
// Purpose: Port assertions for dds_core
// Assumes: One clock, synchronous active-high reset
// Notes: Commit checks look two and six edges back; select windows allow two to five edges of pin sync slack
`timescale 1ns/10ps
module dds_core_checker
  import nco_pkg::*;
#(
  parameter int unsigned CODE_W = SCALE_W
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic commit_in,
  input wire logic osc_source_select_in,
  input wire logic [CODE_W-1:0] dac_scale_code_out,
  input wire logic xtal_amp_enable_out,
  input wire logic mult_enable_out,
  input wire logic bypass_select_out,
  input wire logic [1:0] clk_cfg_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_reset_vals: assert property ($fell(rst_in) |-> dac_scale_code_out == SCALE_RST && mult_enable_out)
    else $error("bad reset values");
  a_xtal_off: assert property ($rose(osc_source_select_in) |-> ##[2:5] !xtal_amp_enable_out)
    else $error("crystal amp stays on");
  a_xtal_on: assert property ($fell(osc_source_select_in) |-> ##[2:5] xtal_amp_enable_out)
    else $error("crystal amp stays off");
  a_bypass_excl: assert property (mult_enable_out != bypass_select_out)
    else $error("bypass and multiplier agree");
  a_cfg_bypass: assert property (bypass_select_out |-> clk_cfg_out == CLK_BYPASS)
    else $error("bypass config wrong");
  a_cfg_mult: assert property (!bypass_select_out |-> clk_cfg_out == {1'b0, !xtal_amp_enable_out})
    else $error("multiplier config wrong");
  a_scale_commit: assert property ($changed(dac_scale_code_out) |-> $past(commit_in, 2) && !$past(commit_in, 6))
    else $error("scale moved without commit");
  a_mult_commit: assert property ($changed(mult_enable_out) |-> $past(commit_in, 2) && !$past(commit_in, 6))
    else $error("multiplier moved without commit");
endmodule : dds_core_checker

bind dds_core dds_core_checker #(.CODE_W(CODE_W)) u_dds_core_checker (.*);

/* bench/dds_host.sv */
// Purpose: Host and clock-source model for dds_core
// Assumes: Signals change by NB just after rising edges
// Notes: Idle bus shows inverted last values, never a stale match
`timescale 1ns/10ps
module dds_host
  import nco_pkg::*;
(
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  output logic [ADDR_W-1:0] addr_out = 8'h00,
  output logic [31:0] wdata_out = 32'h0000_0000,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  output logic commit_out = 1'b0,
  output logic sel_out = 1'b0
);
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~v;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    v = rdata_in;
  endtask : rd
  // Held past the sync latency; the low tail keeps rises apart
  task automatic commit();
    @(posedge clk_in);
    commit_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    commit_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : commit
  task automatic select(input logic v);
    @(posedge clk_in);
    sel_out <= v;
    repeat (6) @(posedge clk_in);
  endtask : select
endmodule : dds_host

/* bench/dds_core_tb_top.sv */
// Purpose: Self-checking bench for dds_core
// Assumes: 200 MHz clk_in, host model drives bus and pins
// Notes: Step words are multiples of 2^31 so low bits never matter
`timescale 1ns/10ps
module dds_core_tb_top
  import nco_pkg::*;
;
  logic clk_in;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in;
  logic [31:0] wdata_in, rdata_out, d;
  logic wr_in, rd_in, commit_in, osc_source_select_in;
  logic [PHASE_W-1:0] phase_out, p0, dp;
  logic [SCALE_W-1:0] dac_scale_code_out;
  logic xtal_amp_enable_out, mult_enable_out, bypass_select_out;
  logic [1:0] clk_cfg_out;
  int mismatches = 0;
  int checks_done = 0;
  dds_core u_dds_core (.*);
  dds_host u_dds_host (.clk_in(clk_in), .rdata_in(rdata_out), .addr_out(addr_in), .wdata_out(wdata_in),
    .wr_out(wr_in), .rd_out(rd_in), .commit_out(commit_in), .sel_out(osc_source_select_in));
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : cmp
  task automatic complete_run();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    u_dds_host.rd(REG_SCALE, d);
    cmp(d, SCALE_RST, "reset scale");
    cmp((120 * (73728 + 192 * d) / 1024) inside {[19989:20011]}, 1'b1, "scale not near 20 mA");
    u_dds_host.rd(8'h40, d);
    cmp(d, 32'h0000_0000, "unmapped read");
  endtask : t_reset
  task automatic t_accum();
    // Step words are round(2^48 f/fs) for exact ratios of fs
    logic [47:0] s [5] = '{48'h0002_0000_0000, 48'h0004_0000_0000, 48'h0000_8000_0000,
      48'hFFFC_0000_0000, 48'h8000_0000_0000};
    logic [47:0] e;
    u_dds_host.wr(REG_STEP_HI, 32'h0000_0004);
    u_dds_host.rd(REG_STEP_HI, d);
    cmp(d, 32'h0000_0000, "uncommitted step");
    foreach (s[i])
    begin
      u_dds_host.wr(REG_STEP_LO, s[i][31:0]);
      u_dds_host.wr(REG_STEP_HI, {16'h0000, s[i][47:32]});
      u_dds_host.commit();
      p0 = phase_out;
      repeat (8) @(posedge clk_in);
      dp = phase_out - p0;
      e = s[i] << 3;
      cmp(dp, e[47:34], "step advance");
    end
  endtask : t_accum
  task automatic t_offset();
    u_dds_host.wr(REG_STEP_LO, 32'h0000_0000);
    u_dds_host.wr(REG_STEP_HI, 32'h0000_0000);
    u_dds_host.wr(REG_SCALE, 32'h0000_03FF);
    u_dds_host.commit();
    p0 = phase_out;
    u_dds_host.wr(REG_PHASE, 32'h0000_3FF0);
    u_dds_host.commit();
    dp = phase_out - p0;
    cmp(dp, 14'h3FF0, "phase offset");
    cmp(dac_scale_code_out, 10'h03FF, "scale code");
  endtask : t_offset
  task automatic t_clk();
    // Expected {xtal, mult, bypass, cfg} per powerdown and select pairing
    logic [4:0] x [4] = '{5'h17, 5'h07, 5'h09, 5'h18};
    for (int i = 0; i < 4; i++)
    begin
      u_dds_host.wr(REG_CTRL, (i < 2) ? 32'h0000_0010 : 32'h0000_0000);
      u_dds_host.commit();
      u_dds_host.select(i == 1 || i == 2);
      cmp({xtal_amp_enable_out, mult_enable_out, bypass_select_out, clk_cfg_out}, x[i], "clocks");
      u_dds_host.rd(REG_CTRL, d);
      cmp(d, (i < 2) ? 32'h0000_0010 : 32'h0000_0000, "powerdown readback");
      u_dds_host.rd(REG_STATUS, d);
      cmp(d, {28'h000_0000, 1'b0, ~x[i][4], x[i][1:0]}, "status readback");
    end
  endtask : t_clk
  task automatic t_rereset();
    rst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    u_dds_host.rd(REG_PHASE, d);
    cmp(d, 32'h0000_0000, "offset after reset");
    cmp(dac_scale_code_out, SCALE_RST, "scale after reset");
  endtask : t_rereset
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_accum();
    t_offset();
    t_clk();
    t_rereset();
    complete_run();
  end
endmodule : dds_core_tb_top
